/* File: core/wwdt_top.sv */
// Windowed watchdog with prescaler, postscaler and AXI4-Lite registers.
// Assumes core events arrive on MCLK_I; RC oscillator is an asynchronous pin.
//
// Overview of operation
// - Count from the RC oscillator; enable that oscillator whenever the watchdog runs.
// - Prescaler divides by 32 or 128 per the width select bit.
// - Prescaler period is the base time-out, about 1 ms or 4 ms.
// - Postscaler divides by one of 16 ratios, 1:1 to 1:32768.
// - Any device reset zeroes counter, prescaler and postscaler.
// - A finished clock switch zeroes all counts.
// - Entering sleep or idle zeroes all counts.
// - Leaving sleep or idle zeroes all counts.
// - Clear instruction in normal run zeroes all counts, subject to the window.
// - An enabled watchdog keeps counting in sleep and idle.
// - Time-out in sleep or idle wakes the core instead of resetting.
// - Time-out sets a sticky flag that only software clears.
// - In windowed mode a clear restarts only in the final quarter.
// - In windowed mode an early clear causes a watchdog reset.
// - Windowed mode is active when the window disable bit is zero.
// - Configuration enable bit set runs the watchdog unconditionally.
// - Otherwise the watchdog runs only while the software enable bit is set.
// - Every device reset clears the software enable bit.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
module wwdt_top #(
   parameter int ADDR_W = 4
) (
   input  wire logic                MCLK_I,
   input  wire logic                RST_B_I,
   input  wire logic                LOW_POWER_RC_OSC_I,
   output logic                     LOW_POWER_RC_OSC_EN_O,
   input  wire wwdt_pkg::wwdt_cfg1_t CONFIG_WORD_ONE_I,
   input  wire wwdt_pkg::wwdt_evt_t  EVENT_I,
   output logic                     WDT_RESET_O,
   output logic                     WAKE_O,
   input  wire logic [ADDR_W-1:0]   AXI_AWADDR_I,
   input  wire logic                AXI_AWVALID_I,
   output logic                     AXI_AWREADY_O,
   input  wire logic [31:0]         AXI_WDATA_I,
   input  wire logic [3:0]          AXI_WSTRB_I,
   input  wire logic                AXI_WVALID_I,
   output logic                     AXI_WREADY_O,
   output logic [1:0]               AXI_BRESP_O,
   output logic                     AXI_BVALID_O,
   input  wire logic                AXI_BREADY_I,
   input  wire logic [ADDR_W-1:0]   AXI_ARADDR_I,
   input  wire logic                AXI_ARVALID_I,
   output logic                     AXI_ARREADY_O,
   output logic [31:0]              AXI_RDATA_O,
   output logic [1:0]               AXI_RRESP_O,
   output logic                     AXI_RVALID_O,
   input  wire logic                AXI_RREADY_I
);
   import wwdt_pkg::*;

   // ***************************************************************
   // Elaboration checks
   // ***************************************************************
   if (ADDR_W < 3 || ADDR_W > 32)
   begin : g_bad_addr
      $error("ADDR_W must lie between 3 and 32");
   end
   if ((1 << PRE_SHORT_BITS) * 1000 / OSC_KHZ > 2 * BASE_SHORT_US ||
       (1 << PRE_LONG_BITS) * 1000 / OSC_KHZ > 2 * BASE_LONG_US)
   begin : g_bad_base
      $error("Prescaler does not match the base time-out");
   end

   logic                 osc_s;
   logic                 osc_prev_q;
   logic                 tick_w;
   logic                 enabled_w;
   logic                 run_w;
   logic                 win_en_w;
   logic                 in_win_w;
   logic                 pre_last_w;
   logic                 post_last_w;
   logic                 timeout_w;
   logic                 early_clr_w;
   logic                 good_clr_w;
   logic                 dog_rst_w;
   logic                 wake_w;
   logic                 restart_w;
   logic [PRE_W-1:0]     pre_q;
   logic [POST_W-1:0]    post_q;
   logic [TOTAL_W-1:0]   elapsed_w;
   logic [TOTAL_W-1:0]   total_w;
   logic [POST_W-1:0]    post_max_w;
   logic                 soft_on_q;
   logic                 timeout_flag_q;
   logic                 sleep_flag_q;
   logic                 idle_flag_q;
   wwdt_pm_t             pm_q;
   logic                 aw_hold_q;
   logic                 w_hold_q;
   logic [ADDR_W-1:0]    aw_addr_q;
   logic [31:0]          w_data_q;
   logic [3:0]           w_strb_q;
   logic                 aw_have_w;
   logic                 w_have_w;
   logic                 do_write_w;
   logic [ADDR_W-1:0]    wr_addr_w;
   logic [31:0]          wr_data_w;
   logic [3:0]           wr_strb_w;
   logic                 rc_wr_w;
   logic [31:0]          rd_data_w;
   logic                 rd_ok_w;

   // ***************************************************************
   // Oscillator input
   // ***************************************************************
   // Oscillator pin passes two flops before edge detection
   wwdt_sync u_osc_sync (
      .clk_i   (MCLK_I),
      .rst_b_i (RST_B_I),
      .async_i (LOW_POWER_RC_OSC_I),
      .sync_o  (osc_s)
   );

   // Previous synchronised level for rising-edge detection
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
         osc_prev_q <= 1'b0;
      else
         osc_prev_q <= osc_s;
   end

   assign tick_w                = osc_s & ~osc_prev_q;
   assign enabled_w             = CONFIG_WORD_ONE_I.config_watchdog_on | soft_on_q;
   assign LOW_POWER_RC_OSC_EN_O = enabled_w;

   // ***************************************************************
   // Time-out arithmetic
   // ***************************************************************
   // Prescaler end by width select, postscaler end by ratio select
   assign pre_last_w  = CONFIG_WORD_ONE_I.prescale_width_select ?
                        (pre_q == PRE_LONG_MAX) : (pre_q == PRE_SHORT_MAX);
   assign post_max_w  = POST_W'((32'h1 << CONFIG_WORD_ONE_I.postscale_ratio_select) - 32'h1);
   assign post_last_w = (post_q == post_max_w);
   assign elapsed_w   = CONFIG_WORD_ONE_I.prescale_width_select ?
                        TOTAL_W'({post_q, pre_q}) :
                        TOTAL_W'({post_q, pre_q[PRE_SHORT_BITS-1:0]});
   assign total_w     = TOTAL_W'(32'h1 << (CONFIG_WORD_ONE_I.postscale_ratio_select +
                        (CONFIG_WORD_ONE_I.prescale_width_select ? PRE_LONG_BITS : PRE_SHORT_BITS)));
   assign in_win_w    = elapsed_w >= (total_w - (total_w >> 2));
   assign win_en_w    = ~CONFIG_WORD_ONE_I.window_disable;
   assign run_w       = (pm_q == PM_RUN);

   // Events that end or restart the count
   assign timeout_w   = enabled_w & tick_w & pre_last_w & post_last_w;
   assign early_clr_w = EVENT_I.clear_watchdog_instruction & run_w &
                        enabled_w & win_en_w & ~in_win_w;
   assign good_clr_w  = EVENT_I.clear_watchdog_instruction & run_w & ~early_clr_w;
   assign dog_rst_w   = (timeout_w & run_w) | early_clr_w;
   assign wake_w      = timeout_w & ~run_w;
   assign restart_w   = EVENT_I.other_reset | dog_rst_w | wake_w |
                        EVENT_I.clock_switch_done |
                        (EVENT_I.power_save_instruction & run_w) |
                        (EVENT_I.exit_low_power & ~run_w) |
                        good_clr_w | ~enabled_w;

   // ***************************************************************
   // Counters
   // ***************************************************************
   // Prescaler and postscaler; also run in sleep and idle
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I || restart_w)
      begin
         pre_q  <= '0;
         post_q <= '0;
      end
      else if (tick_w)
      begin
         if (pre_last_w)
         begin
            pre_q  <= '0;
            post_q <= post_last_w ? '0 : POST_W'(post_q + 1'b1);
         end
         else
            pre_q <= PRE_W'(pre_q + 1'b1);
      end
   end

   // ***************************************************************
   // Power mode tracking
   // ***************************************************************
   // Run, sleep or idle as told by the core
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I || EVENT_I.other_reset || dog_rst_w)
         pm_q <= PM_RUN;
      else
      begin
         case (pm_q)
            PM_RUN:
               if (EVENT_I.power_save_instruction)
                  pm_q <= EVENT_I.enter_idle ? PM_IDLE : PM_SLEEP;
            PM_SLEEP, PM_IDLE:
               if (EVENT_I.exit_low_power || wake_w)
                  pm_q <= PM_RUN;
            default:
               pm_q <= PM_RUN;
         endcase
      end
   end

   // Reset and wake pulses, one cycle each
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
      begin
         WDT_RESET_O <= 1'b0;
         WAKE_O      <= 1'b0;
      end
      else
      begin
         WDT_RESET_O <= dog_rst_w;
         WAKE_O      <= wake_w;
      end
   end

   // ***************************************************************
   // AXI4-Lite write channel
   // ***************************************************************
   assign AXI_AWREADY_O = ~aw_hold_q & ~AXI_BVALID_O;
   assign AXI_WREADY_O  = ~w_hold_q & ~AXI_BVALID_O;
   assign aw_have_w     = aw_hold_q | (AXI_AWVALID_I & AXI_AWREADY_O);
   assign w_have_w      = w_hold_q | (AXI_WVALID_I & AXI_WREADY_O);
   assign do_write_w    = aw_have_w & w_have_w;
   assign wr_addr_w     = aw_hold_q ? aw_addr_q : AXI_AWADDR_I;
   assign wr_data_w     = w_hold_q ? w_data_q : AXI_WDATA_I;
   assign wr_strb_w     = w_hold_q ? w_strb_q : AXI_WSTRB_I;
   assign rc_wr_w       = do_write_w & (wr_addr_w == ADDR_W'(REG_RESET_CTRL)) & wr_strb_w[0];

   // Hold address and data until both have arrived, then respond
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
      begin
         aw_hold_q    <= 1'b0;
         w_hold_q     <= 1'b0;
         aw_addr_q    <= '0;
         w_data_q     <= DATA_RESET;
         w_strb_q     <= 4'h0;
         AXI_BVALID_O <= 1'b0;
         AXI_BRESP_O  <= RESP_OKAY;
      end
      else if (do_write_w)
      begin
         aw_hold_q    <= 1'b0;
         w_hold_q     <= 1'b0;
         AXI_BVALID_O <= 1'b1;
         AXI_BRESP_O  <= (wr_addr_w == ADDR_W'(REG_RESET_CTRL) ||
                          wr_addr_w == ADDR_W'(REG_STATUS)) ? RESP_OKAY : RESP_SLVERR;
      end
      else
      begin
         if (AXI_AWVALID_I && AXI_AWREADY_O)
         begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= AXI_AWADDR_I;
         end
         if (AXI_WVALID_I && AXI_WREADY_O)
         begin
            w_hold_q <= 1'b1;
            w_data_q <= AXI_WDATA_I;
            w_strb_q <= AXI_WSTRB_I;
         end
         if (AXI_BVALID_O && AXI_BREADY_I)
            AXI_BVALID_O <= 1'b0;
      end
   end

   // ***************************************************************
   // Reset control register
   // ***************************************************************
   // Software enable, cleared by every device reset
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I || EVENT_I.other_reset || dog_rst_w)
         soft_on_q <= 1'b0;
      else if (rc_wr_w)
         soft_on_q <= wr_data_w[RC_SOFT_ON_BIT];
   end

   // Sticky flags: hardware set wins over a software write of zero
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
      begin
         timeout_flag_q <= 1'b0;
         sleep_flag_q   <= 1'b0;
         idle_flag_q    <= 1'b0;
      end
      else
      begin
         timeout_flag_q <= dog_rst_w | wake_w |
                           (timeout_flag_q & ~(rc_wr_w & ~wr_data_w[RC_TIMEOUT_BIT]));
         sleep_flag_q   <= (EVENT_I.power_save_instruction & run_w & ~EVENT_I.enter_idle) |
                           (sleep_flag_q & ~(rc_wr_w & ~wr_data_w[RC_SLEEP_BIT]));
         idle_flag_q    <= (EVENT_I.power_save_instruction & run_w & EVENT_I.enter_idle) |
                           (idle_flag_q & ~(rc_wr_w & ~wr_data_w[RC_IDLE_BIT]));
      end
   end

   // ***************************************************************
   // AXI4-Lite read channel
   // ***************************************************************
   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rd_data_w = DATA_RESET;
      rd_ok_w   = 1'b1;
      case (AXI_ARADDR_I)
         ADDR_W'(REG_RESET_CTRL):
         begin
            rd_data_w[RC_SOFT_ON_BIT] = soft_on_q;
            rd_data_w[RC_TIMEOUT_BIT] = timeout_flag_q;
            rd_data_w[RC_SLEEP_BIT]   = sleep_flag_q;
            rd_data_w[RC_IDLE_BIT]    = idle_flag_q;
         end
         ADDR_W'(REG_STATUS):
         begin
            rd_data_w[ST_RUN_BIT] = enabled_w;
            rd_data_w[ST_WIN_BIT] = in_win_w;
            rd_data_w[ST_ELAP_LSB +: TOTAL_W] = elapsed_w;
         end
         default:
            rd_ok_w = 1'b0;
      endcase
   end

   assign AXI_ARREADY_O = ~AXI_RVALID_O;

   // One read in flight; data registered with the valid
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
      begin
         AXI_RVALID_O <= 1'b0;
         AXI_RDATA_O  <= DATA_RESET;
         AXI_RRESP_O  <= RESP_OKAY;
      end
      else if (AXI_ARVALID_I && AXI_ARREADY_O)
      begin
         AXI_RVALID_O <= 1'b1;
         AXI_RDATA_O  <= rd_data_w;
         AXI_RRESP_O  <= rd_ok_w ? RESP_OKAY : RESP_SLVERR;
      end
      else if (AXI_RVALID_O && AXI_RREADY_I)
         AXI_RVALID_O <= 1'b0;
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_osc_on;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      $rose(pre_q != '0) |-> $past(LOW_POWER_RC_OSC_EN_O);
   endproperty
   a_osc_on: assert property (p_osc_on) else $error("Count advanced with oscillator off");

   property p_pre_short;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (tick_w && !restart_w && pre_q == 7'h1F && !CONFIG_WORD_ONE_I.prescale_width_select)
      |=> (pre_q == 7'h00);
   endproperty
   a_pre_short: assert property (p_pre_short) else $error("Short prescaler did not wrap at 32");

   property p_post_end;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      timeout_w |-> (elapsed_w == total_w - 1'b1);
   endproperty
   a_post_end: assert property (p_post_end) else $error("Time-out at wrong elapsed count");

   property p_other_reset;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      EVENT_I.other_reset |=> (pre_q == '0 && post_q == '0 && !soft_on_q);
   endproperty
   a_other_reset: assert property (p_other_reset) else $error("Device reset left counts or enable");

   property p_clk_switch;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      EVENT_I.clock_switch_done |=> (pre_q == '0 && post_q == '0);
   endproperty
   a_clk_switch: assert property (p_clk_switch) else $error("Clock switch did not clear counts");

   property p_enter_low;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (EVENT_I.power_save_instruction && run_w && !dog_rst_w && !EVENT_I.other_reset)
      |=> (pm_q != PM_RUN && pre_q == '0);
   endproperty
   a_enter_low: assert property (p_enter_low) else $error("Power save entry mishandled");

   property p_keep_counting;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (!run_w && tick_w && !restart_w && !pre_last_w) |=> (pre_q == $past(pre_q) + 7'h01);
   endproperty
   a_keep_counting: assert property (p_keep_counting) else $error("Count stalled in low power");

   property p_wake;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (timeout_w && !run_w) |=> (WAKE_O && !WDT_RESET_O) ##1 (!WAKE_O && pm_q == PM_RUN);
   endproperty
   a_wake: assert property (p_wake) else $error("Low power time-out did not wake");

   property p_flag;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      timeout_w |=> timeout_flag_q;
   endproperty
   a_flag: assert property (p_flag) else $error("Time-out flag not set");

   property p_early_clear;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (EVENT_I.clear_watchdog_instruction && run_w && enabled_w &&
       !CONFIG_WORD_ONE_I.window_disable && !in_win_w) |=> WDT_RESET_O;
   endproperty
   a_early_clear: assert property (p_early_clear) else $error("Early clear gave no reset");

   property p_cfg_on;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (!CONFIG_WORD_ONE_I.config_watchdog_on && !soft_on_q) |=> (pre_q == '0 && post_q == '0);
   endproperty
   a_cfg_on: assert property (p_cfg_on) else $error("Disabled watchdog still counting");

   property p_run_timeout;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (timeout_w && run_w) |=> WDT_RESET_O ##1 !WDT_RESET_O;
   endproperty
   a_run_timeout: assert property (p_run_timeout) else $error("Run time-out gave no single reset");

endmodule : wwdt_top

/* File: include/wwdt_pkg.sv */
// Shared constants and carrier types of the windowed watchdog.
// Assumes one system clock; the RC oscillator arrives as a slow plain input.
package wwdt_pkg;

   // ***************************************************************
   // Oscillator and time-out base
   // ***************************************************************
   localparam int OSC_KHZ        = 31;   // Nominal RC oscillator rate
   localparam int BASE_SHORT_US  = 1000; // Base time-out, 5-bit prescaler
   localparam int BASE_LONG_US   = 4000; // Base time-out, 7-bit prescaler
   localparam int PRE_SHORT_BITS = 5;    // Divide by 32
   localparam int PRE_LONG_BITS  = 7;    // Divide by 128
   localparam int PRE_W          = 7;
   localparam int POST_W         = 15;   // Up to 1:32768
   localparam int TOTAL_W        = 23;   // Prescaler plus postscaler span

   localparam logic [PRE_W-1:0] PRE_SHORT_MAX = 7'h1F;
   localparam logic [PRE_W-1:0] PRE_LONG_MAX  = 7'h7F;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [3:0]  REG_RESET_CTRL = 4'h0;
   localparam logic [3:0]  REG_STATUS     = 4'h4;
   localparam int          RC_SOFT_ON_BIT = 5;
   localparam int          RC_TIMEOUT_BIT = 4;
   localparam int          RC_SLEEP_BIT   = 3;
   localparam int          RC_IDLE_BIT    = 2;
   localparam int          ST_RUN_BIT     = 0;
   localparam int          ST_WIN_BIT     = 1;
   localparam int          ST_ELAP_LSB    = 8;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [31:0] DATA_RESET     = 32'h0000_0000;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   // Configuration word one, low byte
   typedef struct packed {
      logic       config_watchdog_on;     // Bit 7
      logic       window_disable;         // Bit 6
      logic       spare;                  // Bit 5
      logic       prescale_width_select;  // Bit 4, 1 = divide by 128
      logic [3:0] postscale_ratio_select; // Bits 3..0, ratio 2**n
   } wwdt_cfg1_t;

   // One-cycle events from the core on the system clock
   typedef struct packed {
      logic power_save_instruction;
      logic enter_idle;
      logic exit_low_power;
      logic clear_watchdog_instruction;
      logic clock_switch_done;
      logic other_reset;
   } wwdt_evt_t;

   typedef enum logic [2:0] {
      PM_RUN   = 3'b001,
      PM_SLEEP = 3'b010,
      PM_IDLE  = 3'b100
   } wwdt_pm_t;

endpackage : wwdt_pkg

/* File: core/wwdt_sync.sv */
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the input changes far slower than the clock.
module wwdt_sync (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_q;

   // ***************************************************************
   // Two stages; only the second stage reads the first
   // ***************************************************************
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : wwdt_sync

/* File: test/wwdt_top_tb.sv */
// Self-checking testbench of the windowed watchdog top.
// Assumes wwdt_pkg is compiled first; the bench drives the RC pin, events and the register bus.
module wwdt_top_tb import wwdt_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        MCLK_I = 1'h0, RST_B_I = 1'h0, LOW_POWER_RC_OSC_I = 1'h0;
   logic        LOW_POWER_RC_OSC_EN_O, WDT_RESET_O, WAKE_O;
   wwdt_cfg1_t  CONFIG_WORD_ONE_I = 8'h00;
   wwdt_evt_t   EVENT_I = 6'h00;
   logic [3:0]  AXI_AWADDR_I = 4'h0, AXI_ARADDR_I = 4'h0, AXI_WSTRB_I = 4'hF;
   logic [31:0] AXI_WDATA_I = 32'h0, AXI_RDATA_O;
   logic        AXI_AWVALID_I = 1'h0, AXI_WVALID_I = 1'h0, AXI_BREADY_I = 1'h0;
   logic        AXI_ARVALID_I = 1'h0, AXI_RREADY_I = 1'h0;
   logic        AXI_AWREADY_O, AXI_WREADY_O, AXI_BVALID_O, AXI_ARREADY_O, AXI_RVALID_O;
   logic [1:0]  AXI_BRESP_O, AXI_RRESP_O;
   int          bad_count = 0, n_checks = 0, n_rst = 0, n_wake = 0;
   // ***************************************************************
   // Clock, pulse counters and device
   // ***************************************************************
   always #25 MCLK_I = ~MCLK_I;
   // Count one-cycle reset and wake pulses
   always @(posedge MCLK_I)
   begin
      n_rst  <= n_rst + int'(WDT_RESET_O === 1'h1);
      n_wake <= n_wake + int'(WAKE_O === 1'h1);
   end
   wwdt_top dut (.*);
   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report
   task hang;
      bad_count++;
      final_report;
   endtask : hang
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk
   // Wait, bounded, until a handshake signal is high before the next edge
   task automatic wt(ref logic s);
      int i;
      @(negedge MCLK_I);
      for (i = 0; s !== 1'h1; i++)
      begin
         if (i > 60) hang;
         @(negedge MCLK_I);
      end
   endtask : wt
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic tw;
      AXI_AWADDR_I <= a;
      AXI_WDATA_I <= d;
      AXI_AWVALID_I <= 1'h1;
      AXI_WVALID_I <= 1'h1;
      AXI_BREADY_I <= 1'h1;
      wt(AXI_AWREADY_O);
      tw = AXI_WREADY_O;
      @(posedge MCLK_I);
      AXI_AWVALID_I <= 1'h0;
      if (!tw)
      begin
         wt(AXI_WREADY_O);
         @(posedge MCLK_I);
      end
      AXI_WVALID_I <= 1'h0;
      wt(AXI_BVALID_O);
      chk(AXI_BRESP_O, RESP_OKAY);
      @(posedge MCLK_I);
      AXI_BREADY_I <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
      AXI_ARADDR_I <= a;
      AXI_ARVALID_I <= 1'h1;
      AXI_RREADY_I <= 1'h1;
      wt(AXI_ARREADY_O);
      @(posedge MCLK_I);
      AXI_ARVALID_I <= 1'h0;
      wt(AXI_RVALID_O);
      chk(AXI_RDATA_O, e);
      chk(AXI_RRESP_O, er);
      @(posedge MCLK_I);
      AXI_RREADY_I <= 1'h0;
      @(posedge MCLK_I);
   endtask : rd
   // Oscillator ticks: pin high for three system clocks, low for four between ticks
   task tk(input int n);
      repeat (n)
      begin
         @(posedge MCLK_I) LOW_POWER_RC_OSC_I <= 1'h1;
         repeat (3) @(posedge MCLK_I);
         LOW_POWER_RC_OSC_I <= 1'h0;
         repeat (3) @(posedge MCLK_I);
      end
   endtask : tk
   // One-cycle core event; masks 20 sleep, 30 idle, 08 exit, 04 clear, 02 switch, 01 reset
   task ev(input logic [5:0] m);
      EVENT_I <= m;
      @(posedge MCLK_I) EVENT_I <= 6'h00;
      repeat (2) @(posedge MCLK_I);
   endtask : ev
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task s_soft;
      rd(REG_RESET_CTRL, 32'h0, RESP_OKAY);
      rd(4'h8, 32'h0, RESP_SLVERR);
      chk(LOW_POWER_RC_OSC_EN_O, 1'h0);
      tk(40);
      chk(n_rst, 0);
      wr(REG_RESET_CTRL, 32'h20);
      chk(LOW_POWER_RC_OSC_EN_O, 1'h1);
      tk(31);
      chk(n_rst, 0);
      tk(1);
      chk(n_rst, 1);
      rd(REG_RESET_CTRL, 32'h10, RESP_OKAY);
      wr(REG_RESET_CTRL, 32'h0);
      rd(REG_RESET_CTRL, 32'h0, RESP_OKAY);
   endtask : s_soft
   task s_restart;
      logic [5:0] tbl [3] = '{6'h04, 6'h02, 6'h01};
      int j, k;
      CONFIG_WORD_ONE_I <= 8'hD0;
      ev(6'h01);
      k = n_rst;
      for (j = 0; j < 3; j++)
      begin
         tk(100);
         ev(tbl[j]);
         tk(127);
         chk(n_rst, k);
         tk(1);
         chk(n_rst, k + 1);
         k++;
      end
   endtask : s_restart
   task s_sleep;
      int k;
      wr(REG_RESET_CTRL, 32'h0);
      CONFIG_WORD_ONE_I <= 8'hC0;
      ev(6'h01);
      k = n_rst;
      ev(6'h30);
      tk(20);
      ev(6'h08);
      tk(31);
      chk(n_rst, k);
      tk(1);
      chk(n_rst, k + 1);
      tk(20);
      ev(6'h20);
      tk(31);
      chk(n_wake, 0);
      tk(1);
      chk(n_wake, 1);
      chk(n_rst, k + 1);
      rd(REG_RESET_CTRL, 32'h1C, RESP_OKAY);
      wr(REG_RESET_CTRL, 32'h0);
      rd(REG_RESET_CTRL, 32'h0, RESP_OKAY);
      ev(6'h01);
   endtask : s_sleep
   task s_window;
      int k;
      CONFIG_WORD_ONE_I <= 8'h81;
      ev(6'h01);
      k = n_rst;
      tk(47);
      ev(6'h04);
      chk(n_rst, k + 1);
      tk(48);
      rd(REG_STATUS, 32'h3003, RESP_OKAY);
      ev(6'h04);
      chk(n_rst, k + 1);
      tk(63);
      chk(n_rst, k + 1);
      tk(1);
      chk(n_rst, k + 2);
   endtask : s_window
   // Main sequence
   initial
   begin
      repeat (8) @(posedge MCLK_I);
      RST_B_I <= 1'h1;
      @(posedge MCLK_I);
      s_soft;
      s_restart;
      s_sleep;
      s_window;
      final_report;
   end
endmodule : wwdt_top_tb
